// [verilog/nbu_uart.sv]
// Nine-bit UART with address wake-up, Avalon-MM register slave and interrupts.
// Assumes serial_rx, ext_baud_clock_pin and shared_ext_irq_input_n are asynchronous pins;
// cascade_timer_three is a one-cycle underflow pulse on ref_clk.
`timescale 1ns/1ps
`default_nettype none
module nbu_uart (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic serial_rx,
  output logic serial_tx,
  input wire logic ext_baud_clock_pin,
  input wire logic cascade_timer_three,
  input wire logic shared_ext_irq_input_n,
  output logic irq,
  output logic vector_irq
);
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic nine;
    logic xbit9;
    logic [7:0] tx_buf;
    logic tx_full;
    logic [5:0] ics;
    logic [3:0] div;
    logic [7:0] rx_buf;
    logic rx_full;
    logic rbit9;
    logic attn;
    logic ferr;
    logic oerr;
    logic [3:0] ists;
    logic [3:0] imask;
    nbu_pkg::nbu_tx_state_t tx_st;
    logic [3:0] tx_cnt;
    logic [3:0] tx_bit;
    logic [8:0] tx_sh;
    logic tx_line;
    nbu_pkg::nbu_rx_state_t rx_st;
    logic [3:0] rx_cnt;
    logic [3:0] rx_bit;
    logic [8:0] rx_sh;
    logic rx1;
    logic rx2;
    logic ck1;
    logic ck2;
    logic ck3;
    logic xi1;
    logic xi2;
    logic irq;
    logic vec;
  } nbu_state_t;

  function automatic logic [3:0] nbu_last_bit(input logic nine);
    nbu_last_bit = nine ? nbu_pkg::LAST_BIT9 : nbu_pkg::LAST_BIT8;
  endfunction : nbu_last_bit

  function automatic logic [8:0] nbu_rx_word(input logic [8:0] sh, input logic nine);
    nbu_rx_word = nine ? sh : {1'b0, sh[8:1]};
  endfunction : nbu_rx_word

  function automatic logic [31:0] nbu_reg_read(input nbu_state_t st, input logic [9:0] a);
    case (a)
      nbu_pkg::IDX_CTRL: nbu_reg_read = {27'h000_0000, st.tx_st != nbu_pkg::NBU_TX_IDLE,
                                         st.nine, st.xbit9, st.rx_full, !st.tx_full};
      nbu_pkg::IDX_ICS: nbu_reg_read = {26'h000_0000, st.ics};
      nbu_pkg::IDX_RXB: nbu_reg_read = {24'h00_0000, st.rx_buf};
      nbu_pkg::IDX_TXB: nbu_reg_read = {24'h00_0000, st.tx_buf};
      nbu_pkg::IDX_RCS: nbu_reg_read = {28'h000_0000, st.attn, st.rbit9, st.oerr, st.ferr};
      nbu_pkg::IDX_DIV: nbu_reg_read = {28'h000_0000, st.div};
      nbu_pkg::IDX_ISTS: nbu_reg_read = {28'h000_0000, st.ists};
      nbu_pkg::IDX_IMASK: nbu_reg_read = {28'h000_0000, st.imask};
      default: nbu_reg_read = 32'h0000_0000;
    endcase
  endfunction : nbu_reg_read

  logic [1:0] rst_sync;
  logic rst_n;
  nbu_state_t s;
  nbu_state_t next_s;
  logic tx_tick;
  logic rx_tick;
  logic ext_rise;
  logic req;
  logic done_wr;
  logic done_rd;
  logic rx_done;
  logic [8:0] rx_word;
  logic rx_keep;
  logic uart_req;

  // Reset release
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  assign ext_rise = s.ck2 && !s.ck3;

  nbu_baud_gen u_tx_baud (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .div_sel(s.div),
    .use_timer(s.ics[nbu_pkg::ICS_TIMER]),
    .timer_underflow(cascade_timer_three),
    .use_ext(s.ics[nbu_pkg::ICS_TX_EXT]),
    .ext_rise(ext_rise),
    .tick(tx_tick)
  );

  nbu_baud_gen u_rx_baud (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .div_sel(s.div),
    .use_timer(s.ics[nbu_pkg::ICS_TIMER]),
    .timer_underflow(cascade_timer_three),
    .use_ext(s.ics[nbu_pkg::ICS_RX_EXT]),
    .ext_rise(ext_rise),
    .tick(rx_tick)
  );

  assign req = avs_read || avs_write;
  assign done_wr = s.ack && avs_write;
  assign done_rd = s.ack && avs_read;
  assign rx_done = (s.rx_st == nbu_pkg::NBU_RX_STOP) && rx_tick && (s.rx_cnt == nbu_pkg::TICK_LAST);
  assign rx_word = nbu_rx_word(s.rx_sh, s.nine);
  assign rx_keep = !s.attn || rx_word[8];
  assign uart_req = (s.ics[nbu_pkg::ICS_TX_IE] && !s.tx_full)
                 || (s.ics[nbu_pkg::ICS_RX_IE] && s.rx_full);

  always_comb begin
    next_s = s;
    // Synchronisers
    next_s.rx1 = serial_rx;
    next_s.rx2 = s.rx1;
    next_s.ck1 = ext_baud_clock_pin;
    next_s.ck2 = s.ck1;
    next_s.ck3 = s.ck2;
    next_s.xi1 = shared_ext_irq_input_n;
    next_s.xi2 = s.xi1;
    // Bus slave, one wait state
    next_s.ack = req && !s.ack;
    if (req && !s.ack && avs_read) begin
      next_s.rdata = nbu_reg_read(s, avs_address);
    end
    if (done_rd && avs_address == nbu_pkg::IDX_RXB) begin
      next_s.rx_full = 1'b0;
    end
    if (done_wr) begin
      case (avs_address)
        nbu_pkg::IDX_CTRL: begin
          next_s.xbit9 = avs_writedata[nbu_pkg::CTL_XBIT9];
          next_s.nine = avs_writedata[nbu_pkg::CTL_NINE];
        end
        nbu_pkg::IDX_ICS: next_s.ics = avs_writedata[nbu_pkg::ICS_W-1:0];
        nbu_pkg::IDX_RCS: begin
          next_s.attn = avs_writedata[nbu_pkg::RCS_ATTN];
          if (avs_writedata[nbu_pkg::RCS_FRAME]) next_s.ferr = 1'b0;
          if (avs_writedata[nbu_pkg::RCS_OVERRUN]) next_s.oerr = 1'b0;
        end
        nbu_pkg::IDX_DIV: next_s.div = avs_writedata[3:0];
        nbu_pkg::IDX_ISTS: next_s.ists = s.ists & ~avs_writedata[nbu_pkg::IRQ_W-1:0];
        nbu_pkg::IDX_IMASK: next_s.imask = avs_writedata[nbu_pkg::IRQ_W-1:0];
        default: next_s.ack = 1'b0;
      endcase
    end
    // Transmitter
    if (tx_tick && s.tx_st != nbu_pkg::NBU_TX_IDLE) begin
      next_s.tx_cnt = s.tx_cnt + 4'h1;
    end
    case (s.tx_st)
      nbu_pkg::NBU_TX_IDLE: begin
        if (s.tx_full) begin
          next_s.tx_sh = {s.xbit9, s.tx_buf};
          next_s.tx_full = 1'b0;
          next_s.tx_line = 1'b0;
          next_s.tx_cnt = 4'h0;
          next_s.tx_bit = 4'h0;
          next_s.tx_st = nbu_pkg::NBU_TX_START;
          next_s.ists[nbu_pkg::IRQ_TX] = 1'b1;
        end
      end
      nbu_pkg::NBU_TX_START: begin
        if (tx_tick && s.tx_cnt == nbu_pkg::TICK_LAST) begin
          next_s.tx_line = s.tx_sh[0];
          next_s.tx_st = nbu_pkg::NBU_TX_DATA;
        end
      end
      nbu_pkg::NBU_TX_DATA: begin
        if (tx_tick && s.tx_cnt == nbu_pkg::TICK_LAST) begin
          if (s.tx_bit == nbu_last_bit(s.nine)) begin
            next_s.tx_line = 1'b1;
            next_s.tx_st = nbu_pkg::NBU_TX_STOP1;
          end else begin
            next_s.tx_sh = {1'b0, s.tx_sh[8:1]};
            next_s.tx_line = s.tx_sh[1];
            next_s.tx_bit = s.tx_bit + 4'h1;
          end
        end
      end
      nbu_pkg::NBU_TX_STOP1: begin
        if (tx_tick && s.tx_cnt == nbu_pkg::TICK_LAST) begin
          next_s.tx_st = s.ics[nbu_pkg::ICS_STOP2] ? nbu_pkg::NBU_TX_STOP2
                                                   : nbu_pkg::NBU_TX_IDLE;
        end
      end
      nbu_pkg::NBU_TX_STOP2: begin
        if (tx_tick && s.tx_cnt == nbu_pkg::TICK_LAST) begin
          next_s.tx_st = nbu_pkg::NBU_TX_IDLE;
        end
      end
      default: next_s.tx_st = nbu_pkg::NBU_TX_IDLE;
    endcase
    if (done_wr && avs_address == nbu_pkg::IDX_TXB) begin
      next_s.tx_buf = avs_writedata[7:0];
      next_s.tx_full = 1'b1;
    end
    // Receiver
    if (rx_tick && s.rx_st != nbu_pkg::NBU_RX_IDLE) begin
      next_s.rx_cnt = s.rx_cnt + 4'h1;
    end
    case (s.rx_st)
      nbu_pkg::NBU_RX_IDLE: begin
        if (!s.rx2) begin
          next_s.rx_cnt = 4'h0;
          next_s.rx_bit = 4'h0;
          next_s.rx_st = nbu_pkg::NBU_RX_START;
        end
      end
      nbu_pkg::NBU_RX_START: begin
        if (rx_tick && s.rx_cnt == nbu_pkg::TICK_MID) begin
          next_s.rx_cnt = 4'h0;
          next_s.rx_st = s.rx2 ? nbu_pkg::NBU_RX_IDLE : nbu_pkg::NBU_RX_DATA;
        end
      end
      nbu_pkg::NBU_RX_DATA: begin
        if (rx_tick && s.rx_cnt == nbu_pkg::TICK_LAST) begin
          next_s.rx_sh = {s.rx2, s.rx_sh[8:1]};
          next_s.rx_bit = s.rx_bit + 4'h1;
          if (s.rx_bit == nbu_last_bit(s.nine)) begin
            next_s.rx_st = nbu_pkg::NBU_RX_STOP;
          end
        end
      end
      nbu_pkg::NBU_RX_STOP: begin
        if (rx_done) begin
          next_s.rx_st = nbu_pkg::NBU_RX_IDLE;
          if (!s.rx2) begin
            next_s.ferr = 1'b1;
            next_s.ists[nbu_pkg::IRQ_ERR] = 1'b1;
          end
          if (rx_keep) begin
            if (next_s.rx_full) begin
              next_s.oerr = 1'b1;
              next_s.ists[nbu_pkg::IRQ_ERR] = 1'b1;
            end
            next_s.rx_buf = rx_word[7:0];
            next_s.rbit9 = rx_word[8];
            next_s.rx_full = 1'b1;
            next_s.ists[nbu_pkg::IRQ_RX] = 1'b1;
            if (s.attn) next_s.ists[nbu_pkg::IRQ_WAKE] = 1'b1;
          end
        end
      end
      default: next_s.rx_st = nbu_pkg::NBU_RX_IDLE;
    endcase
    next_s.irq = |(next_s.ists & next_s.imask);
    next_s.vec = (s.ics[nbu_pkg::ICS_TX_IE] || s.ics[nbu_pkg::ICS_RX_IE]) ? uart_req
                                                                          : !s.xi2;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.tx_line <= 1'b1;
      s.rx1 <= 1'b1;
      s.rx2 <= 1'b1;
      s.xi1 <= 1'b1;
      s.xi2 <= 1'b1;
      s.ics <= nbu_pkg::ICS_RST;
      s.div <= nbu_pkg::DIV_RST;
      s.imask <= nbu_pkg::IMASK_RST;
    end else begin
      s <= next_s;
    end
  end

  assign avs_readdata = s.rdata;
  assign avs_waitrequest = req && !s.ack;
  assign serial_tx = s.tx_line;
  assign irq = s.irq;
  assign vector_irq = s.vec;

  sequence q_tx_stop1_end;
    s.tx_st == nbu_pkg::NBU_TX_STOP1 && tx_tick && s.tx_cnt == nbu_pkg::TICK_LAST;
  endsequence
  sequence q_rx_accept;
    rx_done && rx_keep;
  endsequence

  property p_bus_answer;
    @(posedge ref_clk) disable iff (!rst_n) (req && !s.ack) |=> !avs_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");
  property p_tx_start;
    @(posedge ref_clk) disable iff (!rst_n)
      (s.tx_st == nbu_pkg::NBU_TX_IDLE && s.tx_full) |=> !serial_tx ##1 !serial_tx;
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("no start bit");
  property p_stop_high;
    @(posedge ref_clk) disable iff (!rst_n)
      (s.tx_st == nbu_pkg::NBU_TX_STOP1 || s.tx_st == nbu_pkg::NBU_TX_STOP2) |-> serial_tx;
  endproperty
  a_stop_high: assert property (p_stop_high) else $error("stop bit low");
  property p_two_stop;
    @(posedge ref_clk) disable iff (!rst_n)
      q_tx_stop1_end |=> (s.tx_st == nbu_pkg::NBU_TX_STOP2) == $past(s.ics[nbu_pkg::ICS_STOP2]);
  endproperty
  a_two_stop: assert property (p_two_stop) else $error("stop count wrong");
  property p_ferr;
    @(posedge ref_clk) disable iff (!rst_n) (rx_done && !s.rx2) |=> s.ferr;
  endproperty
  a_ferr: assert property (p_ferr) else $error("framing error missed");
  property p_overrun;
    @(posedge ref_clk) disable iff (!rst_n)
      (q_rx_accept and (s.rx_full && !done_rd)) |=> s.oerr && s.rx_full;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun missed");
  property p_wake;
    @(posedge ref_clk) disable iff (!rst_n)
      (q_rx_accept and (s.attn && rx_word[8])) |=> s.ists[nbu_pkg::IRQ_WAKE] && s.rbit9;
  endproperty
  a_wake: assert property (p_wake) else $error("wake-up not flagged");
  property p_discard;
    @(posedge ref_clk) disable iff (!rst_n)
      (rx_done && s.attn && !rx_word[8] && !s.rx_full) |=> !s.rx_full;
  endproperty
  a_discard: assert property (p_discard) else $error("data frame not skipped");
endmodule : nbu_uart
`default_nettype wire

// [verilog/nbu_pkg.sv]
// Constants, register map and state encodings of the nine-bit wake-up UART.
// Assumes a single 200 MHz core clock.
package nbu_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned BAUD_MAX_HZ = 128_000;
  localparam int unsigned BAUD_MIN_HZ = 8;
  localparam logic [3:0] DIV_SEL_MAX = 4'he;
  localparam int unsigned ACC_W = 28;
  localparam logic [3:0] TICK_LAST = 4'hf;
  localparam logic [3:0] TICK_MID = 4'h7;
  localparam logic [3:0] LAST_BIT8 = 4'h7;
  localparam logic [3:0] LAST_BIT9 = 4'h8;
  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_CTRL = 10'h120;
  localparam logic [9:0] IDX_ICS = 10'h122;
  localparam logic [9:0] IDX_RXB = 10'h124;
  localparam logic [9:0] IDX_TXB = 10'h126;
  localparam logic [9:0] IDX_RCS = 10'h128;
  localparam logic [9:0] IDX_DIV = 10'h12a;
  localparam logic [9:0] IDX_ISTS = 10'h12c;
  localparam logic [9:0] IDX_IMASK = 10'h12e;
  // Control/status fields
  localparam int CTL_TX_EMPTY = 0;
  localparam int CTL_RX_FULL = 1;
  localparam int CTL_XBIT9 = 2;
  localparam int CTL_NINE = 3;
  localparam int CTL_TX_BUSY = 4;
  // Interrupt and clock select fields
  localparam int ICS_W = 6;
  localparam int ICS_STOP2 = 0;
  localparam int ICS_TX_EXT = 1;
  localparam int ICS_RX_EXT = 2;
  localparam int ICS_TX_IE = 3;
  localparam int ICS_RX_IE = 4;
  localparam int ICS_TIMER = 5;
  // Receive control/status fields
  localparam int RCS_FRAME = 0;
  localparam int RCS_OVERRUN = 1;
  localparam int RCS_RBIT9 = 2;
  localparam int RCS_ATTN = 3;
  // Sticky interrupt status fields
  localparam int IRQ_W = 4;
  localparam int IRQ_TX = 0;
  localparam int IRQ_RX = 1;
  localparam int IRQ_WAKE = 2;
  localparam int IRQ_ERR = 3;
  localparam logic [3:0] DIV_RST = 4'h0;
  localparam logic [5:0] ICS_RST = 6'h00;
  localparam logic [3:0] IMASK_RST = 4'h0;

  typedef enum logic [2:0] {
    NBU_TX_IDLE = 3'b000,
    NBU_TX_START = 3'b001,
    NBU_TX_DATA = 3'b010,
    NBU_TX_STOP1 = 3'b011,
    NBU_TX_STOP2 = 3'b100
  } nbu_tx_state_t;

  typedef enum logic [1:0] {
    NBU_RX_IDLE = 2'b00,
    NBU_RX_START = 2'b01,
    NBU_RX_DATA = 2'b10,
    NBU_RX_STOP = 2'b11
  } nbu_rx_state_t;
endpackage : nbu_pkg

// [verilog/nbu_baud_gen.sv]
// Oversampling baud tick for one direction of the UART.
// Assumes ext_rise and timer_underflow are one-cycle pulses on ref_clk.
`timescale 1ns/1ps
`default_nettype none
module nbu_baud_gen (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [3:0] div_sel,
  input wire logic use_timer,
  input wire logic timer_underflow,
  input wire logic use_ext,
  input wire logic ext_rise,
  output logic tick
);
  typedef struct packed {
    logic [nbu_pkg::ACC_W-1:0] acc;
    logic tick;
  } nbu_bg_state_t;

  nbu_bg_state_t s;
  nbu_bg_state_t next_s;
  logic [3:0] sel;
  logic [nbu_pkg::ACC_W-1:0] rate;
  logic [nbu_pkg::ACC_W-1:0] sum;

  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    sel = (div_sel > nbu_pkg::DIV_SEL_MAX) ? nbu_pkg::DIV_SEL_MAX : div_sel;
    rate = nbu_pkg::ACC_W'(nbu_pkg::BAUD_MAX_HZ >> sel);
    sum = s.acc + rate;
    if (use_ext) begin
      next_s.tick = ext_rise;
    end else if (use_timer) begin
      next_s.tick = timer_underflow;
    end else if (sum >= nbu_pkg::ACC_W'(nbu_pkg::CLK_HZ)) begin
      next_s.acc = sum - nbu_pkg::ACC_W'(nbu_pkg::CLK_HZ);
      next_s.tick = 1'b1;
    end else begin
      next_s.acc = sum;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;

  property p_cascade_tick;
    @(posedge ref_clk) disable iff (!rst_n)
      (!use_ext && use_timer && timer_underflow) |=> tick;
  endproperty
  a_cascade_tick: assert property (p_cascade_tick) else $error("cascade underflow lost");
endmodule : nbu_baud_gen
`default_nettype wire

// [test/nbu_serial_node.sv]
// Behavioural far-side serial node: sends frames, decodes frames from the UART.
// Assumes the bench sets bit_clks and nine before each transfer.
`timescale 1ns/1ps
`default_nettype none
module nbu_serial_node (
  input wire logic ref_clk,
  input wire logic line_in,
  output logic line_out
);
  int bit_clks = 64;
  logic nine = 1'b0;
  logic [8:0] got_q[$];
  realtime start_q[$];
  logic [8:0] sh;
  initial line_out = 1'b1;

  // Start low, data LSB first, one stop of given level, then idle high
  task automatic send(input logic [8:0] w, input logic nb, input logic stop_bit);
    logic [10:0] f;
    f = nb ? {stop_bit, w, 1'b0} : {1'b1, stop_bit, w[7:0], 1'b0};
    for (int i = 0; i < (nb ? 11 : 10); i++) begin
      line_out <= f[i];
      repeat (bit_clks) @(posedge ref_clk);
    end
    line_out <= 1'b1;
    @(posedge ref_clk);
  endtask : send

  // Centre sampling of frames from the UART
  always begin
    @(negedge line_in);
    start_q.push_back($realtime);
    repeat (bit_clks / 2) @(posedge ref_clk);
    for (int i = 0; i < (nine ? 9 : 8); i++) begin
      repeat (bit_clks) @(posedge ref_clk);
      sh[i] = line_in;
    end
    if (!nine) sh[8] = 1'b0;
    repeat (bit_clks) @(posedge ref_clk);
    got_q.push_back(sh);
  end
endmodule : nbu_serial_node
`default_nettype wire

// [test/tb_nine_bit_uart_wakeup.sv]
// Self-checking bench of the nine-bit wake-up UART.
// Assumes the far-side node model and a 200 MHz core clock.
`timescale 1ns/1ps
`default_nettype none
module tb_nine_bit_uart_wakeup;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [9:0] avs_address = 10'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic serial_rx;
  logic serial_tx;
  logic ext_baud_clock_pin = 1'b0;
  logic cascade_timer_three = 1'b0;
  logic shared_ext_irq_input_n = 1'b1;
  logic irq;
  logic vector_irq;
  logic ext_en = 1'b0;
  logic [2:0] div_cnt = 3'h0;
  logic [31:0] rd;
  int bad_count = 0;
  int compares = 0;

  always #2.5 ref_clk = ~ref_clk;

  // Timer tick every 4 clocks, external rise every 8 clocks
  always @(posedge ref_clk) begin
    div_cnt <= div_cnt + 3'h1;
    cascade_timer_three <= (div_cnt[1:0] == 2'h3);
    ext_baud_clock_pin <= ext_en & div_cnt[2];
  end

  nbu_uart i_nbu_uart (.ref_clk, .arst_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .serial_rx, .serial_tx,
    .ext_baud_clock_pin, .cascade_timer_three, .shared_ext_irq_input_n, .irq, .vector_irq);
  nbu_serial_node i_nbu_serial_node (.ref_clk(ref_clk), .line_in(serial_tx),
    .line_out(serial_rx));

  task automatic summarize();
    $display("TB: %0d compares, %0d mismatches", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize

  task automatic die();
    bad_count++;
    summarize();
  endtask : die

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Avalon request held until waitrequest seen low at an edge
  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
    int n;
    logic ok;
    n = 0;
    ok = 1'b0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    while (!ok && n < 20) begin
      @(posedge ref_clk);
      ok = (avs_waitrequest === 1'b0);
      n++;
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
    if (!ok) die();
  endtask : bus

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [9:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(rd, e);
  endtask : rdc

  task automatic poll(input logic [9:0] a, input int b, input logic v);
    int n;
    n = 0;
    bus(1'b0, a, 32'h0000_0000);
    while (rd[b] !== v && n < 4000) begin
      bus(1'b0, a, 32'h0000_0000);
      n++;
    end
    if (n >= 4000) die();
  endtask : poll

  task automatic wait_words(input int k);
    int n;
    n = 0;
    while (i_nbu_serial_node.got_q.size() < k && n < 20000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 20000) die();
  endtask : wait_words

  // Sample irq or vector_irq where settled
  task automatic pin(input logic vec, input logic e);
    @(negedge ref_clk);
    chk({31'h0, vec ? vector_irq : irq}, {31'h0, e});
    @(posedge ref_clk);
  endtask : pin

  task automatic t_reset();
    rdc(nbu_pkg::IDX_CTRL, 32'h0000_0001);
    rdc(nbu_pkg::IDX_ICS, 32'h0000_0000);
    rdc(nbu_pkg::IDX_RCS, 32'h0000_0000);
    rdc(nbu_pkg::IDX_IMASK, 32'h0000_0000);
    wr(10'h000, 32'hffff_ffff);
    rdc(10'h000, 32'h0000_0000);
    wr(nbu_pkg::IDX_DIV, 32'h0000_0003);
    rdc(nbu_pkg::IDX_DIV, 32'h0000_0003);
    wr(nbu_pkg::IDX_DIV, 32'h0000_0000);
    $display("TEST reset done");
  endtask : t_reset

  // Two queued bytes; start-to-start gap gives frame length
  task automatic t_tx(input logic [31:0] ics, input int bitc, input int stops);
    real gap;
    wr(nbu_pkg::IDX_CTRL, 32'h0000_0000);
    wr(nbu_pkg::IDX_ICS, ics);
    ext_en <= ics[nbu_pkg::ICS_TX_EXT];
    i_nbu_serial_node.bit_clks = bitc;
    i_nbu_serial_node.nine = 1'b0;
    i_nbu_serial_node.got_q.delete();
    i_nbu_serial_node.start_q.delete();
    wr(nbu_pkg::IDX_TXB, 32'h0000_005a);
    poll(nbu_pkg::IDX_CTRL, nbu_pkg::CTL_TX_EMPTY, 1'b1);
    wr(nbu_pkg::IDX_TXB, 32'h0000_00c3);
    wait_words(2);
    chk(32'(i_nbu_serial_node.got_q[0]), 32'h0000_005a);
    chk(32'(i_nbu_serial_node.got_q[1]), 32'h0000_00c3);
    gap = (i_nbu_serial_node.start_q[1] - i_nbu_serial_node.start_q[0]) / 5.0;
    gap = gap - real'((9 + stops) * bitc);
    chk({31'h0, gap < bitc / 2 && gap > -bitc / 2}, 32'h0000_0001);
    poll(nbu_pkg::IDX_CTRL, nbu_pkg::CTL_TX_BUSY, 1'b0);
    rdc(nbu_pkg::IDX_ISTS, 32'h0000_0001);
    $display("TEST tx done");
  endtask : t_tx

  task automatic t_tx9();
    wr(nbu_pkg::IDX_ICS, 32'h0000_0020);
    i_nbu_serial_node.nine = 1'b1;
    i_nbu_serial_node.bit_clks = 64;
    for (int k = 0; k < 2; k++) begin
      wr(nbu_pkg::IDX_CTRL, k ? 32'h0000_0008 : 32'h0000_000c);
      i_nbu_serial_node.got_q.delete();
      wr(nbu_pkg::IDX_TXB, 32'h0000_0081);
      wait_words(1);
      chk(32'(i_nbu_serial_node.got_q[0]), k ? 32'h0000_0081 : 32'h0000_0181);
      poll(nbu_pkg::IDX_CTRL, nbu_pkg::CTL_TX_BUSY, 1'b0);
    end
    $display("TEST tx9 done");
  endtask : t_tx9

  task automatic t_rx();
    wr(nbu_pkg::IDX_CTRL, 32'h0000_0000);
    i_nbu_serial_node.nine = 1'b0;
    wr(nbu_pkg::IDX_ISTS, 32'h0000_000f);
    wr(nbu_pkg::IDX_IMASK, 32'h0000_0002);
    i_nbu_serial_node.send(9'h03c, 1'b0, 1'b1);
    poll(nbu_pkg::IDX_CTRL, nbu_pkg::CTL_RX_FULL, 1'b1);
    pin(1'b0, 1'b1);
    rdc(nbu_pkg::IDX_RXB, 32'h0000_003c);
    rdc(nbu_pkg::IDX_CTRL, 32'h0000_0001);
    rdc(nbu_pkg::IDX_RCS, 32'h0000_0000);
    wr(nbu_pkg::IDX_ISTS, 32'h0000_0002);
    pin(1'b0, 1'b0);
    i_nbu_serial_node.send(9'h096, 1'b0, 1'b1);
    i_nbu_serial_node.send(9'h069, 1'b0, 1'b1);
    rdc(nbu_pkg::IDX_RCS, 32'h0000_0002);
    rdc(nbu_pkg::IDX_RXB, 32'h0000_0069);
    wr(nbu_pkg::IDX_RCS, 32'h0000_0002);
    rdc(nbu_pkg::IDX_RCS, 32'h0000_0000);
    // Receiver on the external pin, transmitter left on the timer
    wr(nbu_pkg::IDX_ICS, 32'h0000_0024);
    ext_en <= 1'b1;
    i_nbu_serial_node.bit_clks = 128;
    i_nbu_serial_node.send(9'h0a5, 1'b0, 1'b1);
    rdc(nbu_pkg::IDX_RXB, 32'h0000_00a5);
    wr(nbu_pkg::IDX_ICS, 32'h0000_0020);
    i_nbu_serial_node.bit_clks = 64;
    $display("TEST rx done");
  endtask : t_rx

  task automatic t_frame();
    wr(nbu_pkg::IDX_ISTS, 32'h0000_000f);
    i_nbu_serial_node.send(9'h055, 1'b0, 1'b0);
    rdc(nbu_pkg::IDX_RCS, 32'h0000_0001);
    rdc(nbu_pkg::IDX_ISTS, 32'h0000_000a);
    rdc(nbu_pkg::IDX_RXB, 32'h0000_0055);
    repeat (1500) @(posedge ref_clk);
    bus(1'b0, nbu_pkg::IDX_RXB, 32'h0000_0000);
    wr(nbu_pkg::IDX_RCS, 32'h0000_0003);
    $display("TEST framing done");
  endtask : t_frame

  task automatic t_wake();
    wr(nbu_pkg::IDX_CTRL, 32'h0000_0008);
    wr(nbu_pkg::IDX_RCS, 32'h0000_0008);
    wr(nbu_pkg::IDX_ISTS, 32'h0000_000f);
    wr(nbu_pkg::IDX_IMASK, 32'h0000_0004);
    i_nbu_serial_node.send(9'h042, 1'b1, 1'b1);
    rdc(nbu_pkg::IDX_CTRL, 32'h0000_0009);
    pin(1'b0, 1'b0);
    i_nbu_serial_node.send(9'h1a7, 1'b1, 1'b1);
    rdc(nbu_pkg::IDX_CTRL, 32'h0000_000b);
    rdc(nbu_pkg::IDX_RCS, 32'h0000_000c);
    rdc(nbu_pkg::IDX_ISTS, 32'h0000_0006);
    pin(1'b0, 1'b1);
    rdc(nbu_pkg::IDX_RXB, 32'h0000_00a7);
    wr(nbu_pkg::IDX_ISTS, 32'h0000_0004);
    pin(1'b0, 1'b0);
    wr(nbu_pkg::IDX_RCS, 32'h0000_0000);
    $display("TEST wake done");
  endtask : t_wake

  task automatic t_vec();
    wr(nbu_pkg::IDX_ICS, 32'h0000_0028);
    pin(1'b1, 1'b1);
    wr(nbu_pkg::IDX_ICS, 32'h0000_0030);
    shared_ext_irq_input_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    pin(1'b1, 1'b0);
    wr(nbu_pkg::IDX_ICS, 32'h0000_0020);
    repeat (4) @(posedge ref_clk);
    pin(1'b1, 1'b1);
    shared_ext_irq_input_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    pin(1'b1, 1'b0);
    $display("TEST vector done");
  endtask : t_vec

  initial begin
    repeat (4) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_reset();
    t_tx(32'h0000_0020, 64, 1);
    t_tx(32'h0000_0021, 64, 2);
    t_tx(32'h0000_0022, 128, 1);
    t_tx9();
    t_rx();
    t_frame();
    t_wake();
    t_vec();
    summarize();
  end
endmodule : tb_nine_bit_uart_wakeup
`default_nettype wire
